// ### pkg/bdm_regs.vh
// Constants for the banked data memory and core register file
`ifndef BDM_REGS_VH
`define BDM_REGS_VH

// Core register offsets within every bank
`define BDM_OFF_IND0 7'h00
`define BDM_OFF_IND1 7'h01
`define BDM_OFF_PCL 7'h02
`define BDM_OFF_STATUS 7'h03
`define BDM_OFF_PTR0L 7'h04
`define BDM_OFF_PTR0H 7'h05
`define BDM_OFF_PTR1L 7'h06
`define BDM_OFF_PTR1H 7'h07
`define BDM_OFF_BANK 7'h08
`define BDM_OFF_ACC 7'h09
`define BDM_OFF_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define BDM_OFF_INTERRUPT_CONTROL 7'h0b

// Bank region boundaries
`define BDM_OFF_PER_LO 7'h0c
`define BDM_OFF_GPR_LO 7'h20
`define BDM_OFF_COM_LO 7'h70
`define BDM_GPR_PER_BANK 80
`define BDM_BANKS 32
`define BDM_BANK_SPECIAL_LO 5'h1b
`define BDM_BANK_SPECIAL_HI 5'h1d
`define BDM_GPR_BYTES 12'h0a00
`define BDM_COM_BYTES 16
`define BDM_LIN_BASE_HI 4'h2
`define BDM_PM_BIT 15

// Status bit positions and reset values
`define BDM_ST_TO 4
`define BDM_ST_PD 3
`define BDM_ST_Z 2
`define BDM_ST_DC 1
`define BDM_ST_C 0
`define BDM_STATUS_RST 8'h18
`define BDM_INTERRUPT_CONTROL_RST 8'h00

// Decoded access targets
`define BDM_TGT_UNIMP 3'h0
`define BDM_TGT_CORE 3'h1
`define BDM_TGT_PER 3'h2
`define BDM_TGT_RAM 3'h3
`define BDM_TGT_PM 3'h4

// ALU operations
`define BDM_OP_NONE 4'h0
`define BDM_OP_ADD 4'h1
`define BDM_OP_SUB 4'h2
`define BDM_OP_AND 4'h3
`define BDM_OP_IOR 4'h4
`define BDM_OP_XOR 4'h5
`define BDM_OP_RRF 4'h6
`define BDM_OP_RLF 4'h7
`define BDM_OP_CLR 4'h8

`endif

// ### logic/bdm_ram.v
// Single-port byte RAM with registered read data
`timescale 1ns/1ps
module bdm_ram #(
  parameter DW = 8,
  parameter AW = 12,
  parameter DEPTH = 2576
) (
  input wire i_sys_clk,
  input wire i_we,
  input wire [AW-1:0] i_addr,
  input wire [DW-1:0] i_wdata,
  output reg [DW-1:0] o_rdata
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // No reset on the array; callers never read before writing sense data
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule // bdm_ram

// ### logic/bdm_core.v
// Banked data memory, core registers and ALU status flags
`timescale 1ns/1ps
`include "bdm_regs.vh"
module bdm_core #(
  parameter RAM_DEPTH = 2576
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_rd_en,
  input wire i_wr_en,
  input wire [6:0] i_file_off,
  input wire [7:0] i_wr_data,
  input wire i_rd_to_acc,
  output wire o_busy,
  output reg o_rd_valid,
  output wire [7:0] o_rd_data,
  input wire i_alu_go,
  input wire [3:0] i_alu_op,
  input wire [7:0] i_alu_a,
  input wire [7:0] i_alu_b,
  output reg [7:0] o_alu_result,
  input wire i_acc_wr,
  input wire [7:0] i_acc_data,
  input wire i_wdt_clear,
  input wire i_sleep,
  input wire i_wdt_timeout,
  output wire o_pm_rd,
  output reg [14:0] o_pm_addr,
  input wire [13:0] i_pm_data,
  output wire o_per_rd,
  output wire o_per_wr,
  output wire [11:0] o_per_addr,
  output wire [7:0] o_per_wdata,
  input wire [7:0] i_per_rdata,
  output wire [7:0] o_status,
  output wire [4:0] o_bank,
  output reg [7:0] o_acc,
  output reg [7:0] o_pcl,
  output wire [7:0] o_program_counter_latch_high,
  output reg [7:0] o_interrupt_control,
  output wire [15:0] o_ptr0,
  output wire [15:0] o_ptr1
);

  // Core register state
  reg [4:0] bank_sel;
  reg [7:0] ptr0_lo, ptr0_hi, ptr1_lo, ptr1_hi;
  reg [6:0] program_counter_latch_high;
  reg flag_to, flag_pd, flag_z, flag_dc, flag_c;

  // Read pipeline state
  reg pm_pend, pm_to_acc, src_ram, ans_to_acc;
  reg [7:0] rd_hold;
  wire [7:0] ram_q;

  // Decode results
  reg [15:0] eff_addr;
  reg from_ptr;
  reg [2:0] tgt;
  reg [11:0] ram_idx, lin_off;
  reg [6:0] core_off, dec_off;
  reg [4:0] dec_bank;
  reg [7:0] core_rd;

  // ALU working values
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] opnd_b;
  reg cin, upd_z, upd_dc, upd_c, next_z, next_dc, next_c;

  wire rd_take, wr_take, status_wr, flags_busy;

  // A request is refused while a program memory fetch is in flight
  assign o_busy = pm_pend;
  assign rd_take = i_rd_en & ~pm_pend;
  assign wr_take = i_wr_en & ~i_rd_en & ~pm_pend;

  // Upper status bits are not stored and always read zero
  assign o_status = {3'b000, flag_to, flag_pd, flag_z, flag_dc, flag_c};
  assign o_bank = bank_sel;
  assign o_program_counter_latch_high = {1'b0, program_counter_latch_high};
  assign o_ptr0 = {ptr0_hi, ptr0_lo};
  assign o_ptr1 = {ptr1_hi, ptr1_lo};
  assign o_pm_rd = pm_pend;

  // Offsets 0 and 1 are the indirect ports; others are direct
  always @* begin
    from_ptr = (i_file_off == `BDM_OFF_IND0) |
               (i_file_off == `BDM_OFF_IND1);
    if (i_file_off == `BDM_OFF_IND0) begin
      eff_addr = {ptr0_hi, ptr0_lo};
    end else if (i_file_off == `BDM_OFF_IND1) begin
      eff_addr = {ptr1_hi, ptr1_lo};
    end else begin
      eff_addr = {4'h0, bank_sel, i_file_off};
    end
  end

  // Map the effective address onto a target and a RAM index
  always @* begin
    tgt = `BDM_TGT_UNIMP;
    ram_idx = 12'h000;
    dec_bank = eff_addr[11:7];
    dec_off = eff_addr[6:0];
    lin_off = eff_addr[11:0];
    core_off = dec_off;
    if (eff_addr[`BDM_PM_BIT]) begin
      tgt = `BDM_TGT_PM;
    end else if (eff_addr[15:12] == `BDM_LIN_BASE_HI) begin
      // Linear window packs every bank's general RAM back to back
      if (lin_off < `BDM_GPR_BYTES) begin
        tgt = `BDM_TGT_RAM;
        ram_idx = lin_off;
      end
    end else if (eff_addr[15:12] == 4'h0) begin
      if (dec_off < `BDM_OFF_PER_LO) begin
        // Pointer aimed at an indirect port would recurse: read zero
        if (!(from_ptr && dec_off < `BDM_OFF_PCL)) begin
          tgt = `BDM_TGT_CORE;
        end
      end else if (dec_off >= `BDM_OFF_COM_LO) begin
        tgt = `BDM_TGT_RAM;
        ram_idx = `BDM_GPR_BYTES + {8'h00, dec_off[3:0]};
      end else if (dec_bank >= `BDM_BANK_SPECIAL_LO &&
                   dec_bank <= `BDM_BANK_SPECIAL_HI) begin
        tgt = `BDM_TGT_PER;
      end else if (dec_off < `BDM_OFF_GPR_LO) begin
        tgt = `BDM_TGT_PER;
      end else begin
        tgt = `BDM_TGT_RAM;
        ram_idx = {1'b0, dec_bank, 6'h00} + {3'b000, dec_bank, 4'h0} +
                  {5'h00, dec_off} - {5'h00, `BDM_OFF_GPR_LO};
      end
    end
  end

  // Core register read mux; unused offsets give zero
  always @* begin
    case (core_off)
      `BDM_OFF_PCL: core_rd = o_pcl;
      `BDM_OFF_STATUS: core_rd = o_status;
      `BDM_OFF_PTR0L: core_rd = ptr0_lo;
      `BDM_OFF_PTR0H: core_rd = ptr0_hi;
      `BDM_OFF_PTR1L: core_rd = ptr1_lo;
      `BDM_OFF_PTR1H: core_rd = ptr1_hi;
      `BDM_OFF_BANK: core_rd = {3'b000, bank_sel};
      `BDM_OFF_ACC: core_rd = o_acc;
      `BDM_OFF_PROGRAM_COUNTER_LATCH_HIGH: core_rd = o_program_counter_latch_high;
      `BDM_OFF_INTERRUPT_CONTROL: core_rd = o_interrupt_control;
      default: core_rd = 8'h00;
    endcase
  end

  // Peripheral strobes are combinational, data returns same cycle
  assign o_per_rd = rd_take & (tgt == `BDM_TGT_PER);
  assign o_per_wr = wr_take & (tgt == `BDM_TGT_PER);
  assign o_per_addr = eff_addr[11:0];
  assign o_per_wdata = i_wr_data;

  // Physical RAM: general RAM of all banks followed by common RAM
  bdm_ram #(
    .DW(8),
    .AW(12),
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .i_sys_clk(i_sys_clk),
    .i_we(wr_take & (tgt == `BDM_TGT_RAM)),
    .i_addr(ram_idx),
    .i_wdata(i_wr_data),
    .o_rdata(ram_q)
  );

  // Answer comes from the RAM register or the held byte
  assign o_rd_data = src_ram ? ram_q : rd_hold;

  // ALU: subtract is add of the complement plus one
  always @* begin
    opnd_b = (i_alu_op == `BDM_OP_SUB) ? ~i_alu_b : i_alu_b;
    cin = (i_alu_op == `BDM_OP_SUB);
    sum = {1'b0, i_alu_a} + {1'b0, opnd_b} + {8'h00, cin};
    nib = {1'b0, i_alu_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
    upd_z = 1'b0;
    upd_dc = 1'b0;
    upd_c = 1'b0;
    next_dc = nib[4];
    next_c = sum[8];
    case (i_alu_op)
      `BDM_OP_ADD, `BDM_OP_SUB: begin
        o_alu_result = sum[7:0];
        upd_z = 1'b1;
        upd_dc = 1'b1;
        upd_c = 1'b1;
      end
      `BDM_OP_AND: begin
        o_alu_result = i_alu_a & i_alu_b;
        upd_z = 1'b1;
      end
      `BDM_OP_IOR: begin
        o_alu_result = i_alu_a | i_alu_b;
        upd_z = 1'b1;
      end
      `BDM_OP_XOR: begin
        o_alu_result = i_alu_a ^ i_alu_b;
        upd_z = 1'b1;
      end
      `BDM_OP_RRF: begin
        o_alu_result = {flag_c, i_alu_a[7:1]};
        upd_c = 1'b1;
        next_c = i_alu_a[0];
      end
      `BDM_OP_RLF: begin
        o_alu_result = {i_alu_a[6:0], flag_c};
        upd_c = 1'b1;
        next_c = i_alu_a[7];
      end
      `BDM_OP_CLR: begin
        o_alu_result = 8'h00;
        upd_z = 1'b1;
      end
      default: begin
        o_alu_result = i_alu_a;
      end
    endcase
    next_z = (o_alu_result == 8'h00);
  end

  // Status is a write target; a flag-setting op masks the data bits
  assign status_wr = wr_take & (tgt == `BDM_TGT_CORE) &
                     (core_off == `BDM_OFF_STATUS);
  assign flags_busy = i_alu_go & (upd_z | upd_dc | upd_c);

  // Arithmetic flags: data write only when no flag-setting op runs, flag logic next
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_z <= 1'b0;
      flag_dc <= 1'b0;
      flag_c <= 1'b0;
    end else begin
      if (status_wr && !flags_busy) begin
        flag_z <= i_wr_data[`BDM_ST_Z];
        flag_dc <= i_wr_data[`BDM_ST_DC];
        flag_c <= i_wr_data[`BDM_ST_C];
      end
      if (i_alu_go && upd_z) begin
        flag_z <= next_z;
      end
      if (i_alu_go && upd_dc) begin
        flag_dc <= next_dc;
      end
      if (i_alu_go && upd_c) begin
        flag_c <= next_c;
      end
    end
  end

  // Reset status flags; software writes never reach them
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_to <= 1'b1;
      flag_pd <= 1'b1;
    end else begin
      // Time-out is the rarer event and wins over a same-cycle clear
      if (i_wdt_timeout) begin
        flag_to <= 1'b0;
      end else if (i_wdt_clear || i_sleep) begin
        flag_to <= 1'b1;
      end
      if (i_sleep) begin
        flag_pd <= 1'b0;
      end else if (i_wdt_clear) begin
        flag_pd <= 1'b1;
      end
    end
  end

  // Plain core register writes
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_sel <= 5'h00;
      ptr0_lo <= 8'h00;
      ptr0_hi <= 8'h00;
      ptr1_lo <= 8'h00;
      ptr1_hi <= 8'h00;
      program_counter_latch_high <= 7'h00;
      o_pcl <= 8'h00;
      o_interrupt_control <= `BDM_INTERRUPT_CONTROL_RST;
    end else if (wr_take && tgt == `BDM_TGT_CORE) begin
      case (core_off)
        `BDM_OFF_PCL: o_pcl <= i_wr_data;
        `BDM_OFF_PTR0L: ptr0_lo <= i_wr_data;
        `BDM_OFF_PTR0H: ptr0_hi <= i_wr_data;
        `BDM_OFF_PTR1L: ptr1_lo <= i_wr_data;
        `BDM_OFF_PTR1H: ptr1_hi <= i_wr_data;
        `BDM_OFF_BANK: bank_sel <= i_wr_data[4:0];
        `BDM_OFF_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high <= i_wr_data[6:0];
        `BDM_OFF_INTERRUPT_CONTROL: o_interrupt_control <= i_wr_data;
        default: ;
      endcase
    end
  end

  // Accumulator: returning indirect load, then read answer, then direct load, then bus
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_acc <= 8'h00;
    end else if (pm_pend && pm_to_acc) begin
      o_acc <= i_pm_data[7:0];
    end else if (ans_to_acc) begin
      o_acc <= o_rd_data;
    end else if (i_acc_wr) begin
      o_acc <= i_acc_data;
    end else if (wr_take && tgt == `BDM_TGT_CORE &&
                 core_off == `BDM_OFF_ACC) begin
      o_acc <= i_wr_data;
    end
  end

  // Read pipeline; program memory holds the answer one extra cycle
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pm_pend <= 1'b0;
      pm_to_acc <= 1'b0;
      o_pm_addr <= 15'h0000;
      src_ram <= 1'b0;
      ans_to_acc <= 1'b0;
      rd_hold <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      ans_to_acc <= 1'b0;
      pm_pend <= 1'b0;
      pm_to_acc <= 1'b0;
      if (pm_pend) begin
        // Only the low byte of the program word is returned
        rd_hold <= i_pm_data[7:0];
        src_ram <= 1'b0;
        o_rd_valid <= 1'b1;
      end else if (rd_take) begin
        case (tgt)
          `BDM_TGT_PM: begin
            pm_pend <= 1'b1;
            pm_to_acc <= i_rd_to_acc;
            o_pm_addr <= eff_addr[14:0];
          end
          `BDM_TGT_RAM: begin
            src_ram <= 1'b1;
            o_rd_valid <= 1'b1;
            ans_to_acc <= i_rd_to_acc;
          end
          default: begin
            // Core and peripheral bytes are captured; the rest read zero
            src_ram <= 1'b0;
            rd_hold <= (tgt == `BDM_TGT_CORE) ? core_rd :
                       (tgt == `BDM_TGT_PER) ? i_per_rdata : 8'h00;
            o_rd_valid <= 1'b1;
            ans_to_acc <= i_rd_to_acc;
          end
        endcase
      end
    end
  end

endmodule // bdm_core

// ### test/bdm_far_model.sv
// Far-side model: program memory words and peripheral read data
`timescale 1ns/1ps
module bdm_far_model (
  input wire logic i_sys_clk,
  input wire logic i_pm_rd,
  input wire logic [14:0] i_pm_addr,
  input wire logic i_per_rd,
  input wire logic [11:0] i_per_addr,
  output wire logic [13:0] o_pm_data,
  output wire logic [7:0] o_per_rdata
);
  logic [13:0] pm_last = 14'h0000;
  logic [7:0] per_last = 8'h00;
  // Lines flip every cycle outside a strobe, so stale data never matches
  always @(posedge i_sys_clk) begin
    pm_last <= ~o_pm_data;
    per_last <= ~o_per_rdata;
  end
  assign o_pm_data = i_pm_rd ? (i_pm_addr[13:0] ^ 14'h2a5c) : pm_last;
  assign o_per_rdata = i_per_rd ? (i_per_addr[7:0] ^ 8'h5a) : per_last;
endmodule // bdm_far_model

// ### test/bdm_core_props.sv
// Checker for the data memory port and status flags of the core
`timescale 1ns/1ps
module bdm_core_props (
  input logic i_sys_clk,
  input logic i_resetn,
  input logic i_rd_en,
  input logic i_wr_en,
  input logic [6:0] i_file_off,
  input logic [7:0] i_wr_data,
  input logic o_busy,
  input logic o_rd_valid,
  input logic [7:0] o_rd_data,
  input logic i_alu_go,
  input logic [3:0] i_alu_op,
  input logic [7:0] i_alu_a,
  input logic [7:0] i_alu_b,
  input logic [7:0] o_alu_result,
  input logic i_wdt_clear,
  input logic i_sleep,
  input logic i_wdt_timeout,
  input logic o_pm_rd,
  input logic [14:0] o_pm_addr,
  input logic [13:0] i_pm_data,
  input logic [7:0] o_status,
  input logic [4:0] o_bank,
  input logic [15:0] o_ptr0,
  input logic [15:0] o_ptr1
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // Accepted requests; a write loses to a read in the same cycle
  wire rd_ok = i_rd_en && !o_busy;
  wire wr_ok = i_wr_en && !i_rd_en && !o_busy;
  wire pm0 = i_file_off == 7'h00 && o_ptr0[15];
  wire pm1 = i_file_off == 7'h01 && o_ptr1[15];
  wire quiet = !i_sleep && !i_wdt_clear && !i_wdt_timeout;
  wire [8:0] sum = i_alu_a + i_alu_b;
  wire [4:0] nib = i_alu_a[3:0] + i_alu_b[3:0];
  sequence s_fetch;
    o_busy ##1 (o_rd_valid && !o_busy);
  endsequence
  property p_pm_fetch;
    rd_ok && (pm0 || pm1) |=> s_fetch;
  endproperty
  a_pm_fetch: assert property (p_pm_fetch)
    else $error("program read lacks its extra cycle");
  property p_pm_addr;
    rd_ok && pm1 |=> o_pm_rd && o_pm_addr == $past(o_ptr1[14:0]);
  endproperty
  a_pm_addr: assert property (p_pm_addr)
    else $error("program fetch address wrong");
  property p_pm_low;
    o_pm_rd |=> o_rd_valid && o_rd_data == $past(i_pm_data[7:0]);
  endproperty
  a_pm_low: assert property (p_pm_low)
    else $error("program word low byte not returned");
  property p_pm_nowr;
    wr_ok && (pm0 || pm1) |=> !o_busy && !o_rd_valid;
  endproperty
  a_pm_nowr: assert property (p_pm_nowr)
    else $error("write through pointer started a fetch");
  property p_bank;
    wr_ok && i_file_off == 7'h08 |=> o_bank == $past(i_wr_data[4:0]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select not taken");
  property p_data_lat;
    rd_ok && !pm0 && !pm1 |=> o_rd_valid && !o_busy;
  endproperty
  a_data_lat: assert property (p_data_lat)
    else $error("data read answer late");
  property p_top_zero;
    o_status[7:5] == 3'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("status top bits not zero");
  property p_expiry;
    i_wdt_timeout || i_wdt_clear || i_sleep |=>
      o_status[4] == !$past(i_wdt_timeout);
  endproperty
  a_expiry: assert property (p_expiry)
    else $error("expiry flag wrong");
  property p_sleep;
    i_sleep || i_wdt_clear |=> o_status[3] == !$past(i_sleep);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flag wrong");
  property p_zero;
    i_alu_go && i_alu_op >= 4'h1 && i_alu_op <= 4'h5 |=>
      o_status[2] == ($past(o_alu_result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_add;
    i_alu_go && i_alu_op == 4'h1 |=> o_status[1:0] == $past({nib[4], sum[8]});
  endproperty
  a_add: assert property (p_add)
    else $error("add carries wrong");
  property p_sub;
    i_alu_go && i_alu_op == 4'h2 |=> o_status[1:0] ==
      $past({i_alu_a[3:0] >= i_alu_b[3:0], i_alu_a >= i_alu_b});
  endproperty
  a_sub: assert property (p_sub)
    else $error("subtract borrows wrong");
  property p_rot;
    i_alu_go && i_alu_op[3:1] == 3'h3 |=>
      o_status[0] == $past(i_alu_op[0] ? i_alu_a[7] : i_alu_a[0]);
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate carry wrong");
  property p_clr_st;
    i_alu_go && i_alu_op == 4'h8 && wr_ok && i_file_off == 7'h03 && quiet
      |=> o_status == {3'h0, $past(o_status[4:3]), 1'h1, $past(o_status[1:0])};
  endproperty
  a_clr_st: assert property (p_clr_st)
    else $error("clear of status wrong");
endmodule // bdm_core_props

bind bdm_core bdm_core_props bdm_core_props_inst (.i_sys_clk, .i_resetn,
  .i_rd_en, .i_wr_en, .i_file_off, .i_wr_data, .o_busy, .o_rd_valid,
  .o_rd_data, .i_alu_go, .i_alu_op, .i_alu_a, .i_alu_b, .o_alu_result,
  .i_wdt_clear, .i_sleep, .i_wdt_timeout, .o_pm_rd, .o_pm_addr, .i_pm_data,
  .o_status, .o_bank, .o_ptr0, .o_ptr1);

// ### test/bdm_core_tb_top.sv
// Self-checking bench for the banked data memory core
`timescale 1ns/1ps
`define CHK(gv, xv) begin n_checks++; if ((gv) !== (xv)) begin \
  n_errors++; $display("MISMATCH %0t %h vs %h", $time, gv, xv); end end
module bdm_core_tb_top;
  int n_errors = 0, n_checks = 0, k;
  logic i_sys_clk, i_resetn = 1'h0, i_rd_en = 1'h0, i_wr_en = 1'h0;
  logic i_rd_to_acc = 1'h0, i_alu_go = 1'h0, i_acc_wr = 1'h0;
  logic i_wdt_clear = 1'h0, i_sleep = 1'h0, i_wdt_timeout = 1'h0;
  logic [6:0] i_file_off = 7'h00;
  logic [7:0] i_wr_data = 8'h00, i_alu_a = 8'h00, i_alu_b = 8'h00;
  logic [7:0] i_acc_data = 8'h00, b, lo;
  logic [3:0] i_alu_op = 4'h0;
  logic [31:0] seed = 32'h0001_751e, v;
  logic [15:0] a;
  logic [4:0] e;
  wire o_busy, o_rd_valid, o_pm_rd, o_per_rd;
  wire [7:0] o_rd_data, o_alu_result, i_per_rdata, o_status, o_acc;
  wire [13:0] i_pm_data;
  wire [14:0] o_pm_addr;
  wire [11:0] o_per_addr;
  wire [4:0] o_bank;
  wire [15:0] o_ptr0, o_ptr1;
  wire [29:0] evs = {5'h0c, 5'h1a, 5'h15, 5'h13, 5'h04, 5'h0a};
  bdm_core bdm_core_inst (.i_sys_clk, .i_resetn, .i_rd_en, .i_wr_en,
    .i_file_off, .i_wr_data, .i_rd_to_acc, .o_busy, .o_rd_valid, .o_rd_data,
    .i_alu_go, .i_alu_op, .i_alu_a, .i_alu_b, .o_alu_result, .i_acc_wr,
    .i_acc_data, .i_wdt_clear, .i_sleep, .i_wdt_timeout, .o_pm_rd,
    .o_pm_addr, .i_pm_data, .o_per_rd, .o_per_wr(), .o_per_addr,
    .o_per_wdata(), .i_per_rdata, .o_status, .o_bank, .o_acc, .o_pcl(),
    .o_program_counter_latch_high(), .o_interrupt_control(), .o_ptr0, .o_ptr1);
  bdm_far_model bdm_far_model_inst (.i_sys_clk, .i_pm_rd(o_pm_rd),
    .i_pm_addr(o_pm_addr), .i_per_rd(o_per_rd), .i_per_addr(o_per_addr),
    .o_pm_data(i_pm_data), .o_per_rdata(i_per_rdata));
  // 40 MHz clock
  initial begin
    i_sys_clk = 1'h0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Status expected after one ALU step, from operands and old flags
  function automatic logic [7:0] exp_st(logic [3:0] op, logic [7:0] x, y, s);
    logic [8:0] r;
    r = op == 4'h1 ? x + y : op == 4'h2 ? x - y : op == 4'h3 ? x & y :
      op == 4'h4 ? x | y : op == 4'h5 ? x ^ y : 9'h000;
    exp_st = s;
    if (op < 4'h6 || op == 4'h8) exp_st[2] = r[7:0] == 8'h00;
    if (op == 4'h1) exp_st[1:0] = {x[3:0] + y[3:0] > 15, r[8]};
    if (op == 4'h2) exp_st[1:0] = {x[3:0] >= y[3:0], x >= y};
    if (op[3:1] == 3'h3) exp_st[0] = op[0] ? x[7] : x[0];
  endfunction
  // One request cycle; strobes stay up until the next task replaces them
  task automatic req(logic r, w, logic [6:0] off, logic [7:0] dat);
    i_rd_en = r;
    i_wr_en = w;
    i_alu_go = 1'h0;
    i_file_off = off;
    i_wr_data = dat;
    @(posedge i_sys_clk) #1;
  endtask
  task automatic rd(logic [6:0] off, logic acc, logic [7:0] ev);
    i_rd_to_acc = acc;
    req(1'h1, 1'h0, off, 8'h00);
    i_rd_en = 1'h0;
    repeat (2) if (o_rd_valid !== 1'h1) @(posedge i_sys_clk) #1;
    `CHK(o_rd_valid, 1'h1)
    `CHK(o_rd_data, ev)
    @(posedge i_sys_clk) #1;
  endtask
  // Back-to-back ALU steps, optionally aimed at the status register
  task automatic alu(logic [3:0] op, logic [7:0] x, y, logic w);
    logic [7:0] ev;
    ev = exp_st(op, x, y, o_status);
    i_alu_go = 1'h1;
    i_alu_op = op;
    i_alu_a = x;
    i_alu_b = y;
    i_wr_en = w;
    i_file_off = 7'h03;
    i_wr_data = 8'h00;
    @(posedge i_sys_clk) #1;
    if (op[3:1] == 3'h3) `CHK(o_status[0], ev[0])
    else `CHK(o_status, ev)
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(25 * 5000);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1 i_resetn = 1'h1;
    `CHK(o_status, 8'h18)
    `CHK(o_bank, 5'h00)
    req(1'h0, 1'h1, 7'h03, 8'hff);
    `CHK(o_status, 8'h1f)
    i_acc_data = 8'ha5;
    i_acc_wr = 1'h1;
    req(1'h0, 1'h0, 7'h00, 8'h00);
    i_acc_wr = 1'h0;
    rd(7'h09, 1'h0, 8'ha5);
    rd(7'h03, 1'h0, 8'h1f);
    // Same offset in two banks, common RAM, then the linear window
    for (k = 0; k < 8; k++) begin
      v = rnd();
      b = {3'h0, v[4:0]};
      if (b > 8'h19 && b < 8'h1e) b = b - 8'h08;
      lo = v[14:8] % 8'h50 + 8'h20;
      req(1'h0, 1'h1, 7'h08, b);
      req(1'h0, 1'h1, lo[6:0], v[31:24]);
      req(1'h0, 1'h1, 7'h08, b ^ 8'h01);
      req(1'h0, 1'h1, lo[6:0], ~v[31:24]);
      req(1'h0, 1'h1, {3'h7, v[19:16]}, v[23:16]);
      req(1'h0, 1'h1, 7'h08, b);
      rd(lo[6:0], 1'h0, v[31:24]);
      rd({3'h7, v[19:16]}, 1'h0, v[23:16]);
      a = 16'h2000 + b * 16'h0050 + lo - 16'h0020;
      req(1'h0, 1'h1, 7'h04, a[7:0]);
      req(1'h0, 1'h1, 7'h05, a[15:8]);
      rd(7'h00, 1'h0, v[31:24]);
    end
    req(1'h0, 1'h1, 7'h08, 8'h1b);
    rd(7'h40, 1'h0, 8'hc0 ^ 8'h5a);
    req(1'h0, 1'h1, 7'h06, 8'h00);
    req(1'h0, 1'h1, 7'h07, 8'h2a);
    rd(7'h01, 1'h0, 8'h00);
    // Program memory through each pointer, then a write that must vanish
    for (k = 0; k < 2; k++) begin
      v = rnd();
      req(1'h0, 1'h1, 7'(4 + 2 * k), v[7:0]);
      req(1'h0, 1'h1, 7'(5 + 2 * k), {1'h1, v[14:8]});
      rd(7'(k), 1'h1, v[7:0] ^ 8'h5c);
      `CHK(o_acc, v[7:0] ^ 8'h5c)
      req(1'h0, 1'h1, 7'(k), 8'h77);
      rd(7'(k), 1'h0, v[7:0] ^ 8'h5c);
    end
    alu(4'h1, 8'hff, 8'h01, 1'h0);
    alu(4'h2, 8'h00, 8'h01, 1'h1);
    alu(4'h2, 8'h5a, 8'h5a, 1'h0);
    for (k = 0; k < 40; k++) begin
      v = rnd();
      alu(4'h1 + v[2:0], v[15:8], v[23:16], v[24]);
    end
    alu(4'h1, 8'h88, 8'h88, 1'h0);
    alu(4'h8, 8'h00, 8'h00, 1'h1);
    req(1'h0, 1'h0, 7'h00, 8'h00);
    // Event table: clear, sleep, timeout, then expected expiry and sleep
    for (k = 0; k < 6; k++) begin
      e = evs[k * 5 +: 5];
      {i_wdt_clear, i_sleep, i_wdt_timeout} = e[4:2];
      @(posedge i_sys_clk) #1;
      {i_wdt_clear, i_sleep, i_wdt_timeout} = 3'h0;
      `CHK(o_status[4], e[1])
      `CHK(o_status[3], e[0])
      @(posedge i_sys_clk) #1;
    end
    test_done;
  end
endmodule // bdm_core_tb_top
